//--- hdl/fat_regs.sv
// Frequency alarm limit registers with per-reference alarm status and interrupt.
`timescale 1ns/10ps
// Functional notes
// RULE_01: Read/write limit register with soft and hard fields for every reference.
// RULE_02: Soft limit for all inputs is (upper nibble plus one) times 3.8 ppm, symmetric.
// RULE_03: Soft code 0010 means plus or minus 11.4 ppm, the default soft setting.
// RULE_04: Hard limit is (lower nibble plus one) times 3.81 ppm; 0011 means 15.24 ppm.
// RULE_05: Second read/write limit register applies only to the selected reference.
// RULE_06: Selected reference is checked against its own soft limit nibble.
// RULE_07: Selected-register nibbles convert as (value plus one) times step, symmetric.
// RULE_08: Soft or hard status sets when offset magnitude exceeds the applicable limit.
// RULE_09: Soft alarms are generated only while the soft enable bit is one.
// RULE_10: Hard alarms are generated only while the hard enable bit is one.
module fat_regs
  import fat_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register port
  input wire logic [FAT_ADDR_W-1:0] reg_addr,
  input wire logic [FAT_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [FAT_DATA_W-1:0] reg_rdata,
  // Measurements, one signed offset per reference, valid with meas_valid
  input wire logic [FAT_NUM_REF*FAT_OFS_W-1:0] meas_offset,
  input wire logic meas_valid,
  // Alarm outputs
  output logic [FAT_NUM_REF-1:0] soft_alarm,
  output logic [FAT_NUM_REF-1:0] hard_alarm,
  output logic irq
);
  logic [7:0] all_limits;
  logic [7:0] sel_limits;
  logic [7:0] mon_ctrl;
  logic [3:0] sel_ref;
  logic [1:0] irq_sts;
  logic [1:0] irq_en;
  logic [FAT_DATA_W-1:0] next_reg_rdata;
  logic [7:0] next_all_limits;
  logic [7:0] next_sel_limits;
  logic [7:0] next_mon_ctrl;
  logic [3:0] next_sel_ref;
  logic [1:0] next_irq_sts;
  logic [1:0] next_irq_en;
  logic next_irq;
  logic [FAT_NUM_REF-1:0] soft_over;
  logic [FAT_NUM_REF-1:0] hard_over;
  logic [FAT_NUM_REF-1:0] next_soft_alarm;
  logic [FAT_NUM_REF-1:0] next_hard_alarm;
  logic [FAT_NUM_REF-1:0] soft_clr;
  logic [FAT_NUM_REF-1:0] hard_clr;
  logic soft_event;
  logic hard_event;
  logic soft_en;
  logic hard_en;

  assign soft_en = mon_ctrl[FAT_CTRL_SOFT_EN_BIT];
  assign hard_en = mon_ctrl[FAT_CTRL_HARD_EN_BIT];

  // Each reference uses the shared limits unless it is the selected one.
  genvar gi;
  generate
    for (gi = 0; gi < FAT_NUM_REF; gi++) begin : g_ref
      logic is_sel;
      logic [3:0] soft_code;
      logic [3:0] hard_code;
      assign is_sel = (sel_ref == 4'(gi + 1));
      assign soft_code = is_sel ? sel_limits[FAT_SOFT_MSB:FAT_SOFT_LSB] // RULE_06
                                : all_limits[FAT_SOFT_MSB:FAT_SOFT_LSB]; // RULE_01
      assign hard_code = is_sel ? sel_limits[FAT_HARD_MSB:FAT_HARD_LSB] // RULE_05
                                : all_limits[FAT_HARD_MSB:FAT_HARD_LSB];
      fat_limit_cmp u_cmp (
        .offset(meas_offset[gi*FAT_OFS_W +: FAT_OFS_W]),
        .soft_code(soft_code),
        .hard_code(hard_code),
        .soft_over(soft_over[gi]),
        .hard_over(hard_over[gi])
      );
    end
  endgenerate

  // Status bits are sticky; writing one to a status byte clears those bits.
  always_comb begin
    soft_clr = '0;
    hard_clr = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        FAT_ADDR_SOFT_STS_LO: soft_clr[7:0] = reg_wdata;
        FAT_ADDR_SOFT_STS_HI: soft_clr[FAT_NUM_REF-1:8] = reg_wdata[FAT_NUM_REF-9:0];
        FAT_ADDR_HARD_STS_LO: hard_clr[7:0] = reg_wdata;
        FAT_ADDR_HARD_STS_HI: hard_clr[FAT_NUM_REF-1:8] = reg_wdata[FAT_NUM_REF-9:0];
        default: ;
      endcase
    end
  end

  // Alarm status update; a new alarm wins over a clear in the same cycle.
  always_comb begin
    next_soft_alarm = soft_alarm & ~soft_clr;
    next_hard_alarm = hard_alarm & ~hard_clr;
    soft_event = 1'b0;
    hard_event = 1'b0;
    if (meas_valid) begin
      if (soft_en) begin // RULE_09
        next_soft_alarm = next_soft_alarm | soft_over; // RULE_08
        soft_event = |(soft_over & ~soft_alarm);
      end
      if (hard_en) begin // RULE_10
        next_hard_alarm = next_hard_alarm | hard_over; // RULE_08
        hard_event = |(hard_over & ~hard_alarm);
      end
    end
  end

  // Register writes and interrupt bookkeeping.
  always_comb begin
    next_all_limits = all_limits;
    next_sel_limits = sel_limits;
    next_mon_ctrl = mon_ctrl;
    next_sel_ref = sel_ref;
    next_irq_en = irq_en;
    next_irq_sts = irq_sts;
    if (reg_wr) begin
      unique case (reg_addr)
        FAT_ADDR_ALL_LIMITS: next_all_limits = reg_wdata; // RULE_01
        FAT_ADDR_SEL_LIMITS: next_sel_limits = reg_wdata; // RULE_05
        FAT_ADDR_MON_CTRL: next_mon_ctrl = reg_wdata & 8'h03;
        FAT_ADDR_SEL_REF: next_sel_ref = reg_wdata[3:0];
        FAT_ADDR_IRQ_EN: next_irq_en = reg_wdata[1:0];
        FAT_ADDR_IRQ_CLR: next_irq_sts = irq_sts & ~reg_wdata[1:0];
        default: ;
      endcase
    end
    if (soft_event) begin
      next_irq_sts[FAT_IRQ_SOFT_BIT] = 1'b1;
    end
    if (hard_event) begin
      next_irq_sts[FAT_IRQ_HARD_BIT] = 1'b1;
    end
    next_irq = |(next_irq_sts & next_irq_en);
  end

  // Read data appear in the cycle after the read strobe; unmapped reads give zero.
  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        FAT_ADDR_ALL_LIMITS: next_reg_rdata = all_limits;
        FAT_ADDR_SEL_LIMITS: next_reg_rdata = sel_limits;
        FAT_ADDR_MON_CTRL: next_reg_rdata = mon_ctrl;
        FAT_ADDR_SEL_REF: next_reg_rdata = {4'h0, sel_ref};
        FAT_ADDR_SOFT_STS_LO: next_reg_rdata = soft_alarm[7:0];
        FAT_ADDR_SOFT_STS_HI: next_reg_rdata = {2'b00, soft_alarm[FAT_NUM_REF-1:8]};
        FAT_ADDR_HARD_STS_LO: next_reg_rdata = hard_alarm[7:0];
        FAT_ADDR_HARD_STS_HI: next_reg_rdata = {2'b00, hard_alarm[FAT_NUM_REF-1:8]};
        FAT_ADDR_IRQ_STS: next_reg_rdata = {6'h00, irq_sts};
        FAT_ADDR_IRQ_EN: next_reg_rdata = {6'h00, irq_en};
        default: next_reg_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      all_limits <= FAT_ALL_LIMITS_RST; // RULE_03
      sel_limits <= FAT_SEL_LIMITS_RST;
      mon_ctrl <= FAT_MON_CTRL_RST;
      sel_ref <= FAT_SEL_REF_RST;
      irq_sts <= 2'h0;
      irq_en <= 2'h0;
      irq <= 1'b0;
      soft_alarm <= '0;
      hard_alarm <= '0;
      reg_rdata <= '0;
    end else begin
      all_limits <= next_all_limits;
      sel_limits <= next_sel_limits;
      mon_ctrl <= next_mon_ctrl;
      sel_ref <= next_sel_ref;
      irq_sts <= next_irq_sts;
      irq_en <= next_irq_en;
      irq <= next_irq;
      soft_alarm <= next_soft_alarm;
      hard_alarm <= next_hard_alarm;
      reg_rdata <= next_reg_rdata;
    end
  end
endmodule : fat_regs

//--- hdl/fat_pkg.sv
// Package with register map, field layout, reset values and limit scaling.
package fat_pkg;
  localparam int unsigned FAT_ADDR_W = 8;
  localparam int unsigned FAT_DATA_W = 8;
  localparam int unsigned FAT_NUM_REF = 14;
  localparam int unsigned FAT_OFS_W = 16;
  localparam logic [7:0] FAT_ADDR_ALL_LIMITS = 8'h49;
  localparam logic [7:0] FAT_ADDR_SEL_LIMITS = 8'h4A;
  localparam logic [7:0] FAT_ADDR_MON_CTRL = 8'h50;
  localparam logic [7:0] FAT_ADDR_SEL_REF = 8'h51;
  localparam logic [7:0] FAT_ADDR_SOFT_STS_LO = 8'h52;
  localparam logic [7:0] FAT_ADDR_SOFT_STS_HI = 8'h53;
  localparam logic [7:0] FAT_ADDR_HARD_STS_LO = 8'h54;
  localparam logic [7:0] FAT_ADDR_HARD_STS_HI = 8'h55;
  localparam logic [7:0] FAT_ADDR_IRQ_STS = 8'h56;
  localparam logic [7:0] FAT_ADDR_IRQ_CLR = 8'h57;
  localparam logic [7:0] FAT_ADDR_IRQ_EN = 8'h58;
  localparam int unsigned FAT_SOFT_MSB = 7;
  localparam int unsigned FAT_SOFT_LSB = 4;
  localparam int unsigned FAT_HARD_MSB = 3;
  localparam int unsigned FAT_HARD_LSB = 0;
  localparam int unsigned FAT_CTRL_HARD_EN_BIT = 0;
  localparam int unsigned FAT_CTRL_SOFT_EN_BIT = 1;
  localparam int unsigned FAT_IRQ_SOFT_BIT = 0;
  localparam int unsigned FAT_IRQ_HARD_BIT = 1;
  localparam logic [7:0] FAT_ALL_LIMITS_RST = 8'h23;
  localparam logic [7:0] FAT_SEL_LIMITS_RST = 8'h23;
  localparam logic [7:0] FAT_MON_CTRL_RST = 8'h03;
  localparam logic [3:0] FAT_SEL_REF_RST = 4'h0;
  // Offsets are in units of 0.01 ppm; steps are 3.8 ppm soft and 3.81 ppm hard.
  localparam logic [15:0] FAT_SOFT_STEP = 16'h017C;
  localparam logic [15:0] FAT_HARD_STEP = 16'h017D;
endpackage : fat_pkg

//--- hdl/fat_limit_cmp.sv
// Compares one signed offset magnitude against a soft and a hard limit code.
`timescale 1ns/10ps
module fat_limit_cmp
  import fat_pkg::*;
(
  // Measurement
  input wire logic [FAT_OFS_W-1:0] offset,
  // Limit codes
  input wire logic [3:0] soft_code,
  input wire logic [3:0] hard_code,
  // Results
  output logic soft_over,
  output logic hard_over
);
  logic [FAT_OFS_W-1:0] mag;
  logic [FAT_OFS_W+4:0] soft_lim;
  logic [FAT_OFS_W+4:0] hard_lim;

  always_comb begin
    mag = offset[FAT_OFS_W-1] ? FAT_OFS_W'(-offset) : offset;
    soft_lim = (FAT_OFS_W+5)'(({1'b0, soft_code} + 5'h01) * FAT_SOFT_STEP); // RULE_02
    hard_lim = (FAT_OFS_W+5)'(({1'b0, hard_code} + 5'h01) * FAT_HARD_STEP); // RULE_04
    soft_over = {5'h00, mag} > soft_lim; // RULE_07
    hard_over = {5'h00, mag} > hard_lim; // RULE_07
  end
endmodule : fat_limit_cmp

//--- sim/fat_regs_properties.sv
// Port assertions for the frequency alarm limit registers.
`timescale 1ns/10ps
module fat_chk
  import fat_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [FAT_ADDR_W-1:0] reg_addr,
  input wire logic [FAT_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [FAT_DATA_W-1:0] reg_rdata,
  input wire logic [FAT_NUM_REF*FAT_OFS_W-1:0] meas_offset,
  input wire logic meas_valid,
  input wire logic [FAT_NUM_REF-1:0] soft_alarm,
  input wire logic [FAT_NUM_REF-1:0] hard_alarm,
  input wire logic irq
);
  logic [21:0] sh, next_sh;
  logic [13:0] xs, xh;
  logic [7:0] lim;
  int m;
  always_comb begin
    next_sh = sh;
    if (reg_wr && reg_addr == FAT_ADDR_ALL_LIMITS) next_sh[7:0] = reg_wdata;
    if (reg_wr && reg_addr == FAT_ADDR_SEL_LIMITS) next_sh[15:8] = reg_wdata;
    if (reg_wr && reg_addr == FAT_ADDR_SEL_REF) next_sh[19:16] = reg_wdata[3:0];
    if (reg_wr && reg_addr == FAT_ADDR_MON_CTRL) next_sh[21:20] = reg_wdata[1:0];
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sh <= {FAT_MON_CTRL_RST[1:0], FAT_SEL_REF_RST, FAT_SEL_LIMITS_RST, FAT_ALL_LIMITS_RST};
    end else begin
      sh <= next_sh;
    end
  end
  always_comb begin
    for (int i = 0; i < FAT_NUM_REF; i++) begin
      lim = (sh[19:16] == i + 1) ? sh[15:8] : sh[7:0];
      m = $signed(meas_offset[16*i+:16]);
      m = (m < 0) ? -m : m;
      xs[i] = sh[21] && m > (lim[7:4] + 1) * FAT_SOFT_STEP;
      xh[i] = sh[20] && m > (lim[3:0] + 1) * FAT_HARD_STEP;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0)
    else $error("read data not zero when idle");
  a_read_all: assert property (reg_rd && reg_addr == FAT_ADDR_ALL_LIMITS |=>
    reg_rdata == $past(sh[7:0])) else $error("all limits read wrong");
  a_read_sel: assert property (reg_rd && reg_addr == FAT_ADDR_SEL_LIMITS |=>
    reg_rdata == $past(sh[15:8])) else $error("selected limits read wrong");
  a_soft_set: assert property (meas_valid |=> (soft_alarm & $past(xs)) == $past(xs))
    else $error("soft alarm missed");
  a_hard_set: assert property (meas_valid |=> (hard_alarm & $past(xh)) == $past(xh))
    else $error("hard alarm missed");
  a_soft_gate: assert property ((soft_alarm & ~$past(soft_alarm)) != 0 |->
    $past(meas_valid) && (soft_alarm & ~$past(xs)) == 0) else $error("soft alarm unjustified");
  a_hard_gate: assert property ((hard_alarm & ~$past(hard_alarm)) != 0 |->
    $past(meas_valid) && (hard_alarm & ~$past(xh)) == 0) else $error("hard alarm unjustified");
  a_soft_sticky: assert property ((~soft_alarm & $past(soft_alarm)) != 0 |->
    $past(reg_wr) && $past(reg_addr[7:1]) == 7'h29) else $error("soft alarm dropped");
  a_hard_sticky: assert property ((~hard_alarm & $past(hard_alarm)) != 0 |->
    $past(reg_wr) && $past(reg_addr[7:1]) == 7'h2A) else $error("hard alarm dropped");
endmodule : fat_chk
bind fat_regs fat_chk i_fat_chk (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .meas_offset(meas_offset), .meas_valid(meas_valid), .soft_alarm(soft_alarm),
  .hard_alarm(hard_alarm), .irq(irq));

//--- sim/test_fat_regs.sv
// Self-checking bench for the frequency alarm limit registers.
`timescale 1ns/10ps
module test_fat_regs;
  import fat_pkg::*;
  logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, meas_valid = 0, irq;
  logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata, lim, al, sl;
  logic [223:0] meas_offset = '0, ofs;
  logic [13:0] soft_alarm, hard_alarm, es, eh;
  logic [3:0] sref;
  logic [1:0] en, ie;
  int fail_count = 0, samples_checked = 0, cyc = 0, k;
  fat_regs i_fat_regs (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .meas_offset(meas_offset), .meas_valid(meas_valid), .soft_alarm(soft_alarm),
    .hard_alarm(hard_alarm), .irq(irq));
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  function automatic logic over(input logic [15:0] o, input logic [3:0] c, input int st);
    int m;
    m = $signed(o);
    return ((m < 0) ? -m : m) > (c + 1) * st;
  endfunction : over
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
    @(posedge clk_sys);
  endtask : rd
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(74494));
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(FAT_ADDR_ALL_LIMITS, 8'h23);
    rd(FAT_ADDR_SEL_LIMITS, 8'h23);
    rd(8'h7F, 8'h00);
    repeat (60) begin
      {al, sl, sref, en, ie} = $urandom;
      wr(FAT_ADDR_ALL_LIMITS, al);
      wr(FAT_ADDR_SEL_LIMITS, sl);
      rd(FAT_ADDR_ALL_LIMITS, al);
      rd(FAT_ADDR_SEL_LIMITS, sl);
      wr(FAT_ADDR_SEL_REF, {4'h0, sref});
      wr(FAT_ADDR_MON_CTRL, {6'h00, en});
      wr(FAT_ADDR_IRQ_EN, {6'h00, ie});
      for (int i = 0; i < FAT_NUM_REF; i++) begin
        lim = (sref == i + 1) ? sl : al;
        k = ($urandom_range(1) ? (lim[7:4] + 1) * 380 : (lim[3:0] + 1) * 381) + $urandom_range(2) - 1;
        ofs[16*i+:16] = $urandom_range(1) ? k[15:0] : -k[15:0];
        es[i] = en[1] && over(ofs[16*i+:16], lim[7:4], FAT_SOFT_STEP);
        eh[i] = en[0] && over(ofs[16*i+:16], lim[3:0], FAT_HARD_STEP);
      end
      meas_offset <= ofs;
      meas_valid <= 1'b1;
      @(posedge clk_sys);
      meas_valid <= 1'b0;
      #1;
      chk("soft_alarm", es, soft_alarm);
      chk("hard_alarm", eh, hard_alarm);
      @(posedge clk_sys);
      rd(FAT_ADDR_SOFT_STS_LO, es[7:0]);
      rd(FAT_ADDR_SOFT_STS_HI, {2'b00, es[13:8]});
      rd(FAT_ADDR_HARD_STS_LO, eh[7:0]);
      rd(FAT_ADDR_HARD_STS_HI, {2'b00, eh[13:8]});
      rd(FAT_ADDR_IRQ_STS, {6'h00, |eh, |es});
      rd(FAT_ADDR_IRQ_EN, {6'h00, ie});
      rd(FAT_ADDR_MON_CTRL, {6'h00, en});
      rd(FAT_ADDR_SEL_REF, {4'h0, sref});
      chk("irq", (|es && ie[0]) || (|eh && ie[1]), irq);
      for (int a = 0; a < 4; a++) wr(FAT_ADDR_SOFT_STS_LO + a, 8'hFF);
      wr(FAT_ADDR_IRQ_CLR, 8'h03);
      rd(FAT_ADDR_HARD_STS_LO, 8'h00);
      chk("irq", 1'b0, irq);
    end
    wr(FAT_ADDR_MON_CTRL, 8'h03);
    meas_offset <= {FAT_NUM_REF{16'h7000}};
    meas_valid <= 1'b1;
    reg_addr <= FAT_ADDR_SOFT_STS_LO;
    reg_wdata <= 8'hFF;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    meas_valid <= 1'b0;
    reg_wr <= 1'b0;
    #1;
    chk("soft_alarm", {2'b11, 14'h3FFF}, {2'b11, soft_alarm});
    @(posedge clk_sys);
    end_sim();
  end
endmodule : test_fat_regs
